// ==== rtl/scrb_config_bank.sv ====
`timescale 1ns/1ps
// What this block does
// - Five write-only 20-bit registers at addresses 0x01 to 0x05, 4-bit address.
// - Counter word: bit 19 zero, progr_count bits 18:6, swllw_cnt bits 5:0.
// - Pump register: pump_boost bits 9:6, pump_normal bits 3:0, rest zero.
// - pump_normal sets normal current; pump_boost only during fast lockup.
// - Codes 0-7 give unit times code plus one; code 8 gives half unit.
// - Ref register: dual_mod_ratio bits 15:14, input_div bits 13:0, top zero.
// - Function register: lock count, boost enable, float, sign, lock select, timer.
// - 0x02 and 0x03 are buffered and applied with the next 0x01 write.
// - 0x04 and 0x05 take effect at once, leaving buffers alone.
// - Counter setting applies at the load strobe rise ending the 0x01 write.
// - Modulus code 01 is 16/17, 10 is 32/33, 11 is 64/65, 00 barred.
// - General output bit 1 drives gen_out_two, bit 0 gen_out_one.
module scrb_config_bank (
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Three-wire serial port
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  // Applied counter and pump settings
  output logic [12:0] progr_count_o,
  output logic [5:0] swllw_cnt_o,
  output logic [3:0] pump_normal_o,
  output logic [3:0] pump_boost_o,
  output logic [4:0] pump_normal_half_units_o,
  output logic [4:0] pump_boost_half_units_o,
  // Applied reference and prescaler
  output logic [1:0] dual_mod_ratio_o,
  output logic [6:0] prescale_p_o,
  output logic [13:0] input_div_o,
  // Function settings
  output logic [1:0] lock_count_sel_o,
  output logic boost_enable_o,
  output logic pump_float_o,
  output logic pump_sign_o,
  output logic lock_detect_sel_o,
  output logic [12:0] boost_timer_o,
  // Pins and events
  output logic gen_out_one_o,
  output logic gen_out_two_o,
  output logic freq_update_o
);

  scrb_pkg::scrb_word_t rx_word;
  logic rx_vld;

  // Buffered staging copies
  scrb_pkg::scrb_pump_t pump_buf_ff;
  scrb_pkg::scrb_pump_t nxt_pump_buf;
  scrb_pkg::scrb_refpre_t ref_buf_ff;
  scrb_pkg::scrb_refpre_t nxt_ref_buf;
  // Applied copies
  scrb_pkg::scrb_counter_t cnt_ff;
  scrb_pkg::scrb_counter_t nxt_cnt;
  scrb_pkg::scrb_pump_t pump_ff;
  scrb_pkg::scrb_pump_t nxt_pump;
  scrb_pkg::scrb_refpre_t ref_ff;
  scrb_pkg::scrb_refpre_t nxt_ref;
  scrb_pkg::scrb_func_t func_ff;
  scrb_pkg::scrb_func_t nxt_func;
  scrb_pkg::scrb_genout_t genout_ff;
  scrb_pkg::scrb_genout_t nxt_genout;
  logic upd_ff;
  logic nxt_upd;

  // Pump code to current in half units of the minimum step
  function automatic logic [4:0] pump_half_units(input logic [3:0] code);
    logic [4:0] res;
    res = 5'h00;
    if (code == scrb_pkg::PUMP_HALF_CODE) begin
      res = scrb_pkg::PUMP_HALF_UNITS2;
    end else if (!code[3]) begin
      res = {1'b0, code} + 5'h01;
      res = {res[3:0], 1'b0};
    end
    return res;
  endfunction

  // Modulus code to prescaler P; barred code reads as zero
  function automatic logic [6:0] prescale_of(input logic [1:0] code);
    logic [6:0] p;
    p = 7'h00;
    unique case (code)
      scrb_pkg::DMOD_16: p = 7'h10;
      scrb_pkg::DMOD_32: p = 7'h20;
      scrb_pkg::DMOD_64: p = 7'h40;
      scrb_pkg::DMOD_BAD: p = 7'h00;
    endcase
    return p;
  endfunction

  scrb_serial_rx #(
    .WORD_W(scrb_pkg::WORD_BITS)
  ) u_rx (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i),
    .load_strobe_i(load_strobe_i),
    .word_vld_o(rx_vld),
    .word_o(rx_word)
  );

  // Only named fields are picked out, so fixed-zero bits are dropped
  always_comb begin
    nxt_pump_buf = pump_buf_ff;
    nxt_ref_buf = ref_buf_ff;
    nxt_cnt = cnt_ff;
    nxt_pump = pump_ff;
    nxt_ref = ref_ff;
    nxt_func = func_ff;
    nxt_genout = genout_ff;
    nxt_upd = 1'b0;
    if (rx_vld) begin
      unique case (rx_word.addr)
        scrb_pkg::ADDR_COUNTER: begin
          nxt_cnt.progr_count =
            rx_word.data[scrb_pkg::PROGR_LSB +: scrb_pkg::PROGR_W];
          nxt_cnt.swllw_cnt =
            rx_word.data[scrb_pkg::SWLLW_LSB +: scrb_pkg::SWLLW_W];
          // Staged words go live together with the counter word
          nxt_pump = pump_buf_ff;
          nxt_ref = ref_buf_ff;
          nxt_upd = 1'b1;
        end
        scrb_pkg::ADDR_PUMP: begin
          nxt_pump_buf.pump_boost =
            rx_word.data[scrb_pkg::PBOOST_LSB +: scrb_pkg::PUMP_W];
          nxt_pump_buf.pump_normal =
            rx_word.data[scrb_pkg::PNORM_LSB +: scrb_pkg::PUMP_W];
        end
        scrb_pkg::ADDR_REFPRE: begin
          nxt_ref_buf.dual_mod_ratio =
            rx_word.data[scrb_pkg::DMOD_LSB +: scrb_pkg::DMOD_W];
          nxt_ref_buf.input_div =
            rx_word.data[scrb_pkg::INDIV_LSB +: scrb_pkg::INDIV_W];
        end
        scrb_pkg::ADDR_FUNC: begin
          nxt_func.lock_count_sel = rx_word.data[scrb_pkg::LCSEL_LSB +: 2];
          nxt_func.boost_enable = rx_word.data[scrb_pkg::BOOST_EN_BIT];
          nxt_func.pump_float = rx_word.data[scrb_pkg::PFLOAT_BIT];
          nxt_func.pump_sign = rx_word.data[scrb_pkg::PSIGN_BIT];
          nxt_func.lock_detect_sel = rx_word.data[scrb_pkg::LDSEL_BIT];
          nxt_func.boost_timer =
            rx_word.data[scrb_pkg::BTIMER_LSB +: scrb_pkg::BTIMER_W];
        end
        scrb_pkg::ADDR_GENOUT: begin
          nxt_genout.gen_out_two = rx_word.data[scrb_pkg::GENOUT_TWO_BIT];
          nxt_genout.gen_out_one = rx_word.data[scrb_pkg::GENOUT_ONE_BIT];
        end
        // Unmapped addresses dropped so nothing else is touched
        default: nxt_upd = 1'b0;
      endcase
    end
  end

  // Real part has undefined power-up state; reset to zero keeps sims clean
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pump_buf_ff <= '0;
      ref_buf_ff <= '0;
      cnt_ff <= '0;
      pump_ff <= '0;
      ref_ff <= '0;
      func_ff <= '0;
      genout_ff <= '0;
      upd_ff <= 1'b0;
    end else begin
      pump_buf_ff <= nxt_pump_buf;
      ref_buf_ff <= nxt_ref_buf;
      cnt_ff <= nxt_cnt;
      pump_ff <= nxt_pump;
      ref_ff <= nxt_ref;
      func_ff <= nxt_func;
      genout_ff <= nxt_genout;
      upd_ff <= nxt_upd;
    end
  end

  assign progr_count_o = cnt_ff.progr_count;
  assign swllw_cnt_o = cnt_ff.swllw_cnt;
  assign pump_normal_o = pump_ff.pump_normal;
  assign pump_boost_o = pump_ff.pump_boost;
  assign pump_normal_half_units_o = pump_half_units(pump_ff.pump_normal);
  assign pump_boost_half_units_o = pump_half_units(pump_ff.pump_boost);
  assign dual_mod_ratio_o = ref_ff.dual_mod_ratio;
  assign prescale_p_o = prescale_of(ref_ff.dual_mod_ratio);
  assign input_div_o = ref_ff.input_div;
  assign lock_count_sel_o = func_ff.lock_count_sel;
  assign boost_enable_o = func_ff.boost_enable;
  assign pump_float_o = func_ff.pump_float;
  assign pump_sign_o = func_ff.pump_sign;
  assign lock_detect_sel_o = func_ff.lock_detect_sel;
  assign boost_timer_o = func_ff.boost_timer;
  assign gen_out_one_o = genout_ff.gen_out_one;
  assign gen_out_two_o = genout_ff.gen_out_two;
  assign freq_update_o = upd_ff;

endmodule

// ==== rtl/scrb_pkg.sv ====
package scrb_pkg;

  // Serial word layout
  localparam int WORD_BITS = 24;
  localparam int DATA_BITS = 20;
  localparam int ADDR_BITS = 4;

  // Register addresses
  localparam logic [3:0] ADDR_COUNTER = 4'h1;
  localparam logic [3:0] ADDR_PUMP = 4'h2;
  localparam logic [3:0] ADDR_REFPRE = 4'h3;
  localparam logic [3:0] ADDR_FUNC = 4'h4;
  localparam logic [3:0] ADDR_GENOUT = 4'h5;

  // Counter word fields
  localparam int PROGR_LSB = 6;
  localparam int PROGR_W = 13;
  localparam int SWLLW_LSB = 0;
  localparam int SWLLW_W = 6;
  // Pump current fields
  localparam int PBOOST_LSB = 6;
  localparam int PNORM_LSB = 0;
  localparam int PUMP_W = 4;
  // Reference / prescaler fields
  localparam int DMOD_LSB = 14;
  localparam int DMOD_W = 2;
  localparam int INDIV_LSB = 0;
  localparam int INDIV_W = 14;
  // Function fields
  localparam int LCSEL_LSB = 17;
  localparam int BOOST_EN_BIT = 16;
  localparam int PFLOAT_BIT = 15;
  localparam int PSIGN_BIT = 14;
  localparam int LDSEL_BIT = 13;
  localparam int BTIMER_LSB = 0;
  localparam int BTIMER_W = 13;
  // General outputs
  localparam int GENOUT_TWO_BIT = 1;
  localparam int GENOUT_ONE_BIT = 0;

  // Pump code: 0..7 gives (code+1) units, 8 gives half a unit
  localparam logic [3:0] PUMP_HALF_CODE = 4'h8;
  localparam logic [4:0] PUMP_HALF_UNITS2 = 5'h01;

  // Dual-modulus codes
  localparam logic [1:0] DMOD_BAD = 2'h0;
  localparam logic [1:0] DMOD_16 = 2'h1;
  localparam logic [1:0] DMOD_32 = 2'h2;
  localparam logic [1:0] DMOD_64 = 2'h3;

  // Reset values; the real part has none, zero is our defined choice
  localparam logic [19:0] REG_RST = 20'h00000;

  typedef struct packed {
    logic [12:0] progr_count;
    logic [5:0] swllw_cnt;
  } scrb_counter_t;

  typedef struct packed {
    logic [3:0] pump_boost;
    logic [3:0] pump_normal;
  } scrb_pump_t;

  typedef struct packed {
    logic [1:0] dual_mod_ratio;
    logic [13:0] input_div;
  } scrb_refpre_t;

  typedef struct packed {
    logic [1:0] lock_count_sel;
    logic boost_enable;
    logic pump_float;
    logic pump_sign;
    logic lock_detect_sel;
    logic [12:0] boost_timer;
  } scrb_func_t;

  typedef struct packed {
    logic gen_out_two;
    logic gen_out_one;
  } scrb_genout_t;

  // Data is shifted in first, so it sits above the address
  typedef struct packed {
    logic [19:0] data;
    logic [3:0] addr;
  } scrb_word_t;

endpackage

// ==== rtl/scrb_serial_rx.sv ====
`timescale 1ns/1ps
module scrb_serial_rx #(
  parameter int WORD_W = 24
) (
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pins, asynchronous
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  // Received word
  output logic word_vld_o,
  output logic [WORD_W-1:0] word_o
);

  logic [2:0] clk_sync_ff;
  logic [2:0] nxt_clk_sync;
  logic [2:0] strobe_sync_ff;
  logic [2:0] nxt_strobe_sync;
  logic [1:0] dat_sync_ff;
  logic [1:0] nxt_dat_sync;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] nxt_shift;
  logic [WORD_W-1:0] word_ff;
  logic [WORD_W-1:0] nxt_word;
  logic vld_ff;
  logic nxt_vld;
  logic clk_rise;
  logic strobe_rise;

  // Edges judged on stages two and three only; stage one feeds stage two alone
  always_comb begin
    nxt_clk_sync = {clk_sync_ff[1:0], ser_clk_i};
    nxt_strobe_sync = {strobe_sync_ff[1:0], load_strobe_i};
    nxt_dat_sync = {dat_sync_ff[0], ser_data_i};
    clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
    strobe_rise = strobe_sync_ff[1] & ~strobe_sync_ff[2];
    nxt_shift = shift_ff;
    nxt_word = word_ff;
    nxt_vld = 1'b0;
    // Data delayed like the clock, so it is sampled as of the clock rise
    if (clk_rise) begin
      nxt_shift = {shift_ff[WORD_W-2:0], dat_sync_ff[1]};
    end
    if (strobe_rise) begin
      nxt_word = shift_ff;
      nxt_vld = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_sync_ff <= 3'h0;
      strobe_sync_ff <= 3'h0;
      dat_sync_ff <= 2'h0;
      shift_ff <= '0;
      word_ff <= '0;
      vld_ff <= 1'b0;
    end else begin
      clk_sync_ff <= nxt_clk_sync;
      strobe_sync_ff <= nxt_strobe_sync;
      dat_sync_ff <= nxt_dat_sync;
      shift_ff <= nxt_shift;
      word_ff <= nxt_word;
      vld_ff <= nxt_vld;
    end
  end

  assign word_vld_o = vld_ff;
  assign word_o = word_ff;

endmodule

// ==== verif/scrb_config_bank_properties.sv ====
`timescale 1ns/1ps
module scrb_config_bank_chk (
  // System
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_strobe_i,
  // Watched outputs
  input wire logic [12:0] progr_count_o,
  input wire logic [5:0] swllw_cnt_o,
  input wire logic [3:0] pump_normal_o,
  input wire logic [3:0] pump_boost_o,
  input wire logic [4:0] pump_normal_half_units_o,
  input wire logic [4:0] pump_boost_half_units_o,
  input wire logic [1:0] dual_mod_ratio_o,
  input wire logic [6:0] prescale_p_o,
  input wire logic [13:0] input_div_o,
  input wire logic [12:0] boost_timer_o,
  input wire logic gen_out_one_o,
  input wire logic gen_out_two_o,
  input wire logic freq_update_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_upd_single: assert property (freq_update_o |=> !freq_update_o)
    else $error("update pulse too long");
  chk_upd_cause: assert property (freq_update_o |-> $past(load_strobe_i, 2))
    else $error("update without strobe");
  chk_cnt_hold: assert property (!freq_update_o |->
    $stable({progr_count_o, swllw_cnt_o}))
    else $error("counter moved without update");
  chk_pump_buffered: assert property (!freq_update_o |->
    $stable({pump_normal_o, pump_boost_o}))
    else $error("pump moved without update");
  chk_ref_buffered: assert property (!freq_update_o |->
    $stable({dual_mod_ratio_o, input_div_o}))
    else $error("reference moved without update");
  chk_func_apart: assert property (freq_update_o |->
    $stable({boost_timer_o, gen_out_two_o, gen_out_one_o}))
    else $error("function touched by counter write");
  chk_func_cause: assert property (
    $changed({boost_timer_o, gen_out_two_o, gen_out_one_o}) |-> $past(load_strobe_i, 2))
    else $error("function changed without strobe");
  chk_half_units: assert property (pump_normal_o < 4'h8 |->
    pump_normal_half_units_o == {pump_normal_o, 1'b0} + 5'h02)
    else $error("normal current wrong");
  chk_half_small: assert property (pump_boost_o == 4'h8 |->
    pump_boost_half_units_o == 5'h01)
    else $error("half unit current wrong");
  chk_prescale_map: assert property (dual_mod_ratio_o != 2'h0 |->
    prescale_p_o == (7'h08 << dual_mod_ratio_o))
    else $error("modulus wrong");
endmodule
bind scrb_config_bank scrb_config_bank_chk u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_strobe_i(load_strobe_i),
  .progr_count_o(progr_count_o), .swllw_cnt_o(swllw_cnt_o), .pump_normal_o(pump_normal_o),
  .pump_boost_o(pump_boost_o), .pump_normal_half_units_o(pump_normal_half_units_o),
  .pump_boost_half_units_o(pump_boost_half_units_o), .dual_mod_ratio_o(dual_mod_ratio_o),
  .prescale_p_o(prescale_p_o), .input_div_o(input_div_o), .boost_timer_o(boost_timer_o),
  .gen_out_one_o(gen_out_one_o), .gen_out_two_o(gen_out_two_o), .freq_update_o(freq_update_o)
);

// ==== verif/scrb_host_model.sv ====
`timescale 1ns/1ps
module scrb_host_model (
  // System
  input wire logic clk_i,
  // Serial pins
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // Half of the 160 ns link period
  task automatic tick();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic send(input logic [3:0] addr, input logic [19:0] data);
    logic [23:0] w;
    w = {data, addr};
    for (int i = 23; i >= 0; i--) begin
      ser_data_o <= w[i];
      tick();
      ser_clk_o <= 1'b1;
      tick();
      ser_clk_o <= 1'b0;
    end
    tick();
    // Released data line must not look like a held bit
    ser_data_o <= ~w[0];
    load_strobe_o <= 1'b1;
    tick();
    load_strobe_o <= 1'b0;
    tick();
  endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ser_clk, ser_data, load_strobe;
  logic [12:0] progr, timer;
  logic [5:0] swllw;
  logic [3:0] pn, pb;
  logic [4:0] hn, hb;
  logic [1:0] dmod, lsel;
  logic [6:0] presc;
  logic [13:0] idiv;
  logic ben, pflt, psgn, ldsel, g1, g2, upd;
  int miscompares = 0;
  int tests_run = 0;
  int upd_seen = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  scrb_host_model u_host (.clk_i(clk_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
    .load_strobe_o(load_strobe));
  scrb_config_bank u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ser_clk_i(ser_clk),
    .ser_data_i(ser_data), .load_strobe_i(load_strobe), .progr_count_o(progr),
    .swllw_cnt_o(swllw), .pump_normal_o(pn), .pump_boost_o(pb), .pump_normal_half_units_o(hn),
    .pump_boost_half_units_o(hb), .dual_mod_ratio_o(dmod), .prescale_p_o(presc),
    .input_div_o(idiv), .lock_count_sel_o(lsel), .boost_enable_o(ben), .pump_float_o(pflt),
    .pump_sign_o(psgn), .lock_detect_sel_o(ldsel), .boost_timer_o(timer),
    .gen_out_one_o(g1), .gen_out_two_o(g2), .freq_update_o(upd));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // About 32 words of 408 cycles after the 50 us wait
  always @(posedge clk_i) begin
    cycles++;
    if (upd === 1'b1) begin
      upd_seen++;
    end
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (5000) @(posedge clk_i);
    u_host.send(4'h2, 20'hffd78);
    check("pump_staged", 32'h0, pn);
    u_host.send(4'h3, 20'hf87d0);
    check("div_staged", 32'h0, idiv);
    u_host.send(4'h1, {1'h1, 13'h130b, 6'h14});
    check("progr", 32'h130b, progr);
    check("swllw", 32'h14, swllw);
    check("pump_normal", 32'h8, pn);
    check("pump_boost", 32'h5, pb);
    check("half_normal", 32'h1, hn);
    check("half_boost", 32'hc, hb);
    check("dmod", 32'h2, dmod);
    check("prescale", 32'h20, presc);
    check("div", 32'h7d0, idiv);
    u_host.send(4'h2, 20'h00003);
    u_host.send(4'h4, {1'h0, 2'h2, 4'hb, 13'h04d2});
    check("func", {2'h2, 4'hb, 13'h04d2}, {lsel, ben, pflt, psgn, ldsel, timer});
    u_host.send(4'h5, 20'h00002);
    check("gen_out", 32'h2, {g2, g1});
    check("pump_kept", 32'h8, pn);
    // Every select, enable and flag bit flipped, timer bits only in part, so a stuck flag shows up
    u_host.send(4'h4, {1'h1, 2'h1, 4'h4, 13'h0aaa});
    check("func_flip", {2'h1, 4'h4, 13'h0aaa}, {lsel, ben, pflt, psgn, ldsel, timer});
    u_host.send(4'h5, 20'hffffd);
    check("gen_out_flip", 32'h1, {g2, g1});
    u_host.send(4'h3, {6'h03, 14'h3fff});
    u_host.send(4'h1, {1'h0, 13'h1fff, 6'h3f});
    check("pump_latest", 32'h3, pn);
    check("ref_new", {2'h3, 14'h3fff}, {dmod, idiv});
    check("prescale_64", 32'h40, presc);
    check("cnt_max", {13'h1fff, 6'h3f}, {progr, swllw});
    u_host.send(4'h0, 20'hfffff);
    u_host.send(4'h6, 20'h00000);
    u_host.send(4'hf, 20'h00000);
    check("unmapped", {13'h0aaa, 2'h1, 13'h1fff}, {timer, g2, g1, progr});
    // Smallest modulus, applied by the first counter word of the loop
    u_host.send(4'h3, {6'h01, 14'h0004});
    for (int c = 0; c <= 8; c++) begin
      u_host.send(4'h2, {10'h0, c[3:0], 2'h0, c[3:0]});
      u_host.send(4'h1, {1'h0, 13'h0003, 6'h03});
      check("half_code", (c == 8) ? 32'h1 : 32'(2 * (c + 1)), hn);
      check("half_code_boost", (c == 8) ? 32'h1 : 32'(2 * (c + 1)), hb);
    end
    check("prescale_16", 32'h10, presc);
    check("updates", 32'hb, upd_seen);
    tally_and_finish();
  end
endmodule
